/* File: ddcb_pkg.sv */
// Package of shared constants and types for the downconverter/beamformer acquisition block
package ddcb_pkg;
  localparam int NUM_CH = 3;
  localparam int ADC_W = 16;
  localparam int IQ_W = 24;
  localparam int COEF_W = 18;
  localparam int NUM_TAPS = 8;
  localparam int PWR_W = 32;
  localparam int AVG_MAX = 8192;
  localparam int DECIM_MIN = 2;
  localparam int DECIM_MAX = 65536;
  // Per-channel register window: channel c at CH_BASE + c * CH_STRIDE
  localparam logic [11:0] CH_BASE = 12'h100;
  localparam logic [11:0] CH_STRIDE = 12'h100;
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_TUNE = 8'h04;
  localparam logic [7:0] OFF_DECIM = 8'h08;
  localparam logic [7:0] OFF_GAIN = 8'h0C;
  localparam logic [7:0] OFF_PHASE = 8'h10;
  localparam logic [7:0] OFF_AVG = 8'h14;
  localparam logic [7:0] OFF_THR = 8'h18;
  localparam logic [7:0] OFF_PWR = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_COEF = 8'h40;
  // Global registers
  localparam logic [11:0] REG_SUM_CFG = 12'h000;
  localparam logic [11:0] REG_SUM_GAIN = 12'h004;
  localparam logic [11:0] REG_SUM_AVG = 12'h008;
  localparam logic [11:0] REG_SUM_THR = 12'h00C;
  localparam logic [11:0] REG_SUM_PWR = 12'h010;
  localparam logic [11:0] REG_SUM_STAT = 12'h014;
  localparam logic [11:0] REG_DMA_CTRL = 12'h018;
  localparam logic [11:0] REG_DMA_LEN = 12'h01C;
  localparam logic [11:0] REG_TSTAMP = 12'h020;
  // Reset values and DMA header channel id
  localparam logic [15:0] DECIM_RST = 16'h0001;
  localparam logic [12:0] AVG_RST = 13'h03FF;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [COEF_W-1:0] COEF_DEF = 18'h04000;
  localparam logic [31:0] CH_ID_BASE = 32'h0000_0A00;

  typedef enum logic [2:0] {
    DDCB_SRC_ADC0, DDCB_SRC_ADC1, DDCB_SRC_ADC2, DDCB_SRC_TEST, DDCB_SRC_LOOP
  } ddcb_src_t;

  typedef enum logic [1:0] {DDCB_DMA_IDLE, DDCB_DMA_HDR, DDCB_DMA_DATA} ddcb_dma_state_t;

  typedef struct packed {
    logic signed [IQ_W-1:0] i;
    logic signed [IQ_W-1:0] q;
  } ddcb_iq_t;

  typedef struct packed {
    logic [31:0] data;
    logic hdr;
    logic last;
  } ddcb_word_t;

  typedef struct packed {
    logic [2:0] src;
    logic capture_mode;
    logic narrow_out;
    logic thr_above;
    logic sum_en;
  } ddcb_chcfg_t;
endpackage

/* File: ddcb_acq.sv */
// Acquisition top: source select, downconverters, correction, power meters, beam sum and DMA
//
// Operation
// - Each channel selects one of three A/Ds, test generator or loopback.
// - Channel 1 memory works as streaming FIFO or transient capture store.
// - Gate-driven DMA ends a transfer when the acquisition gate closes.
// - Optional metadata packet holds channel id, sample timestamp and length.
// - Each downconverter has its own 32-bit tuning word, DC to sample rate.
// - Each downconverter has an independent decimation factor from 2 to 65536.
// - Filter uses user-loaded 18-bit coefficients, separate per channel.
// - Default coefficients give passband of 0.8 times decimated rate.
// - Complex output at fs over N: 16-bit I and Q with narrow_out set, else I bits 23:8 and Q bits 15:0.
// - Programmable phase and gain correction precedes the power meter.
// - Power meter averages continuously over programmable interval up to 8K samples.
// - Averaged power per channel is readable from a status register.
// - Each channel interrupts when averaged power crosses a programmable threshold.
// - Summation adds any programmable subset of three corrected channel outputs.
// - Summed output passes a programmable gain stage for bit growth.
// - Summed output has its own power meter and threshold detector.
// - Final summed output is written into channel 1 FIFO.
// - Beam sums of several boards chain over the 48-bit parallel chain_in and chain_out ports.
// - Every A/D input delivers 16-bit samples at up to 200 MHz.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module ddcb_acq #(
  parameter int NCH = ddcb_pkg::NUM_CH,
  parameter int TAPS = ddcb_pkg::NUM_TAPS,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample inputs
  input wire logic [3*ddcb_pkg::ADC_W-1:0] adc_data,
  input wire logic [ddcb_pkg::ADC_W-1:0] test_data,
  input wire logic [ddcb_pkg::ADC_W-1:0] loop_data,
  input wire logic acq_gate,
  // Chained beam sum from the previous board
  input wire logic [2*ddcb_pkg::IQ_W-1:0] chain_in,
  input wire logic chain_in_valid,
  output ddcb_pkg::ddcb_iq_t chain_out,
  output logic chain_out_valid,
  // DMA stream toward the host interface
  output ddcb_pkg::ddcb_word_t dma_word,
  output logic dma_valid,
  input wire logic dma_ready,
  output logic irq
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int SQ_W = 2 * ddcb_pkg::IQ_W;

  logic wr_en;
  logic rd_en;
  logic [7:0] ch_off;
  logic [3:0] ch_sel;
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && penable && !pwrite;
  assign ch_off = paddr[7:0];
  assign ch_sel = paddr[11:8];
  assign pready = 1'b1;

  // Channel and global configuration
  ddcb_pkg::ddcb_chcfg_t cfg [NCH];
  logic [31:0] tune [NCH];
  logic [15:0] decim_m1 [NCH];
  logic [15:0] gain [NCH];
  logic [15:0] phase [NCH];
  logic [12:0] avg_m1 [NCH];
  logic [31:0] thr [NCH];
  logic [ddcb_pkg::COEF_W-1:0] coef [NCH][TAPS];
  logic [NCH-1:0] sum_mask;
  logic [15:0] sum_gain;
  logic [12:0] sum_avg_m1;
  logic [31:0] sum_thr;
  logic sum_thr_above;
  logic chain_en;
  logic dma_gate_mode;
  logic dma_meta_en;
  logic [15:0] dma_len;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < NCH; c++) begin
        cfg[c] <= '0;
        tune[c] <= '0;
        decim_m1[c] <= ddcb_pkg::DECIM_RST;
        gain[c] <= ddcb_pkg::GAIN_UNITY;
        phase[c] <= '0;
        avg_m1[c] <= ddcb_pkg::AVG_RST;
        thr[c] <= '0;
        for (int t = 0; t < TAPS; t++) coef[c][t] <= ddcb_pkg::COEF_DEF;
      end
      sum_mask <= '0;
      sum_gain <= ddcb_pkg::GAIN_UNITY;
      sum_avg_m1 <= ddcb_pkg::AVG_RST;
      sum_thr <= '0;
      sum_thr_above <= 1'b0;
      chain_en <= 1'b0;
      dma_gate_mode <= 1'b0;
      dma_meta_en <= 1'b0;
      dma_len <= '0;
    end else if (wr_en) begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_sel == 4'(c + 1)) begin
          unique case (ch_off)
            ddcb_pkg::OFF_CFG: cfg[c] <= pwdata[6:0];
            ddcb_pkg::OFF_TUNE: tune[c] <= pwdata;
            // Decimation minus one, at least 1
            ddcb_pkg::OFF_DECIM: decim_m1[c] <= (pwdata[15:0] == 16'h0000) ?
                                                16'h0001 : pwdata[15:0];
            ddcb_pkg::OFF_GAIN: gain[c] <= pwdata[15:0];
            ddcb_pkg::OFF_PHASE: phase[c] <= pwdata[15:0];
            ddcb_pkg::OFF_AVG: avg_m1[c] <= pwdata[12:0];
            ddcb_pkg::OFF_THR: thr[c] <= pwdata;
            default: begin
              if (ch_off >= ddcb_pkg::OFF_COEF && ch_off[7:2] < 6'(16 + TAPS))
                coef[c][ch_off[4:2]] <= pwdata[ddcb_pkg::COEF_W-1:0];
            end
          endcase
        end
      end
      if (ch_sel == 4'h0) begin
        unique case (paddr)
          ddcb_pkg::REG_SUM_CFG: begin
            sum_mask <= pwdata[NCH-1:0];
            sum_thr_above <= pwdata[8];
            chain_en <= pwdata[9];
          end
          ddcb_pkg::REG_SUM_GAIN: sum_gain <= pwdata[15:0];
          ddcb_pkg::REG_SUM_AVG: sum_avg_m1 <= pwdata[12:0];
          ddcb_pkg::REG_SUM_THR: sum_thr <= pwdata;
          ddcb_pkg::REG_DMA_CTRL: begin
            dma_gate_mode <= pwdata[0];
            dma_meta_en <= pwdata[1];
          end
          ddcb_pkg::REG_DMA_LEN: dma_len <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Sample timestamp counter
  logic [31:0] tstamp;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) tstamp <= '0;
    else if (clk_en) tstamp <= tstamp + 32'h1;
  end

  // Per-channel datapath
  ddcb_pkg::ddcb_iq_t corr [NCH];
  logic corr_v [NCH];
  logic [31:0] pwr [NCH];
  logic [NCH-1:0] flag;
  logic [NCH-1:0] clr_flag;
  logic [ddcb_pkg::IQ_W-1:0] i_out16;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [ddcb_pkg::ADC_W-1:0] smp;
    logic [31:0] nco;
    logic signed [ddcb_pkg::ADC_W-1:0] lo_i;
    logic signed [ddcb_pkg::ADC_W-1:0] lo_q;
    logic signed [ddcb_pkg::ADC_W-1:0] hist [TAPS];
    logic signed [SQ_W-1:0] acc_i;
    logic signed [SQ_W-1:0] acc_q;
    logic signed [SQ_W-1:0] tap_i;
    logic signed [SQ_W-1:0] tap_q;
    logic [15:0] dcnt;
    logic [2:0] tap_idx;
    ddcb_pkg::ddcb_iq_t dec;
    logic dec_v;

    always_comb begin
      unique case (cfg[c].src)
        3'd0: smp = adc_data[0 +: ddcb_pkg::ADC_W];
        3'd1: smp = adc_data[ddcb_pkg::ADC_W +: ddcb_pkg::ADC_W];
        3'd2: smp = adc_data[2*ddcb_pkg::ADC_W +: ddcb_pkg::ADC_W];
        3'd3: smp = test_data;
        default: smp = loop_data;
      endcase
    end

    // Phase accumulator with coarse quadrature oscillator
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) nco <= '0;
      else if (clk_en) nco <= nco + tune[c];
    end
    always_comb begin
      unique case (nco[31:30])
        2'd0: begin lo_i = smp; lo_q = '0; end
        2'd1: begin lo_i = '0; lo_q = -smp; end
        2'd2: begin lo_i = -smp; lo_q = '0; end
        default: begin lo_i = '0; lo_q = smp; end
      endcase
    end

    // Filter tap product from loaded coefficient
    assign tap_idx = dcnt[2:0];
    assign tap_i = SQ_W'(lo_i) * SQ_W'($signed(coef[c][tap_idx]));
    assign tap_q = SQ_W'(lo_q) * SQ_W'($signed(coef[c][tap_idx]));

    // Integrate-and-dump decimator, one output per N samples
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        dcnt <= '0;
        acc_i <= '0;
        acc_q <= '0;
        dec <= '0;
        dec_v <= 1'b0;
      end else if (clk_en) begin
        dec_v <= 1'b0;
        if (dcnt >= decim_m1[c]) begin
          dcnt <= '0;
          acc_i <= '0;
          acc_q <= '0;
          dec.i <= ddcb_pkg::IQ_W'((acc_i + tap_i) >>> 18);
          dec.q <= ddcb_pkg::IQ_W'((acc_q + tap_q) >>> 18);
          dec_v <= 1'b1;
        end else begin
          dcnt <= dcnt + 16'h1;
          acc_i <= acc_i + tap_i;
          acc_q <= acc_q + tap_q;
        end
      end
    end

    logic signed [SQ_W-1:0] gi;
    logic signed [SQ_W-1:0] gq;
    assign gi = (SQ_W'(dec.i) * SQ_W'($signed({1'b0, gain[c]}))) >>> 14;
    assign gq = ((SQ_W'(dec.q) * SQ_W'($signed({1'b0, gain[c]})))
                 + (SQ_W'(dec.i) * SQ_W'($signed(phase[c])))) >>> 14;
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        corr[c] <= '0;
        corr_v[c] <= 1'b0;
      end else if (clk_en) begin
        corr_v[c] <= dec_v;
        if (dec_v) begin
          corr[c].i <= ddcb_pkg::IQ_W'(gi);
          corr[c].q <= ddcb_pkg::IQ_W'(gq);
        end
      end
    end

    ddcb_pmeter u_pm (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .smp(corr[c]),
      .smp_v(corr_v[c]),
      .avg_m1(avg_m1[c]),
      .thr(thr[c]),
      .above(cfg[c].thr_above),
      .clr(clr_flag[c]),
      .pwr(pwr[c]),
      .flag(flag[c])
    );
  end

  ddcb_pkg::ddcb_iq_t beam;
  logic beam_v;
  logic signed [SQ_W-1:0] si;
  logic signed [SQ_W-1:0] sq;
  always_comb begin
    si = '0;
    sq = '0;
    for (int c = 0; c < NCH; c++) begin
      if (sum_mask[c]) begin
        si = si + SQ_W'(corr[c].i);
        sq = sq + SQ_W'(corr[c].q);
      end
    end
    // Add sum chained from the previous board
    if (chain_en && chain_in_valid) begin
      si = si + SQ_W'($signed(chain_in[SQ_W-1:ddcb_pkg::IQ_W]));
      sq = sq + SQ_W'($signed(chain_in[ddcb_pkg::IQ_W-1:0]));
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      beam <= '0;
      beam_v <= 1'b0;
    end else if (clk_en) begin
      beam_v <= corr_v[0];
      if (corr_v[0]) begin
        beam.i <= ddcb_pkg::IQ_W'((si * SQ_W'($signed({1'b0, sum_gain}))) >>> 14);
        beam.q <= ddcb_pkg::IQ_W'((sq * SQ_W'($signed({1'b0, sum_gain}))) >>> 14);
      end
    end
  end
  // Beam forwarded to the next board
  assign chain_out = beam;
  assign chain_out_valid = beam_v;

  logic [31:0] sum_pwr;
  logic sum_flag;
  logic sum_clr;
  ddcb_pmeter u_sum_pm (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .smp(beam),
    .smp_v(beam_v),
    .avg_m1(sum_avg_m1),
    .thr(sum_thr),
    .above(sum_thr_above),
    .clr(sum_clr),
    .pwr(sum_pwr),
    .flag(sum_flag)
  );
  assign irq = |flag || sum_flag;

  // Channel 1 memory: FIFO stream or capture store
  logic [31:0] mem [FIFO_DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  logic [31:0] push_word;
  assign fifo_full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign fifo_empty = wptr == rptr;
  // Beam or channel-1 sample packed into channel 1 memory
  assign push_word = (|sum_mask) ?
      {beam.i[ddcb_pkg::IQ_W-1 -: 16], beam.q[ddcb_pkg::IQ_W-1 -: 16]} :
      (cfg[0].narrow_out ? {corr[0].i[ddcb_pkg::IQ_W-1 -: 16], corr[0].q[ddcb_pkg::IQ_W-1 -: 16]}
                         : {corr[0].i[ddcb_pkg::IQ_W-1 -: 16], i_out16[15:0]});
  assign i_out16 = corr[0].q;
  // Data only while the gate is open
  assign push = acq_gate && ((|sum_mask) ? beam_v : corr_v[0]) && !fifo_full;

  ddcb_pkg::ddcb_dma_state_t dma_st;
  logic [1:0] hdr_idx;
  logic [15:0] xfer_cnt;
  logic [31:0] xfer_ts;
  logic gate_d;
  logic gate_end;
  assign gate_end = gate_d && !acq_gate;
  logic cap_hold;
  // Capture mode holds the store until the gate closes
  assign cap_hold = cfg[0].capture_mode && acq_gate;
  assign pop = (dma_st == ddcb_pkg::DDCB_DMA_DATA) && dma_ready && !fifo_empty && !cap_hold;

  // Capture mode stops writing when the store fills; FIFO mode streams
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) wptr <= '0;
    else if (clk_en && push) wptr <= wptr + 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (clk_en && push) mem[wptr[AW-1:0]] <= push_word;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rptr <= '0;
    else if (clk_en && pop) rptr <= rptr + 1'b1;
  end

  // DMA: optional header, then data until length or gate close
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dma_st <= ddcb_pkg::DDCB_DMA_IDLE;
      hdr_idx <= '0;
      xfer_cnt <= '0;
      xfer_ts <= '0;
      gate_d <= 1'b0;
    end else if (clk_en) begin
      gate_d <= acq_gate;
      unique case (dma_st)
        ddcb_pkg::DDCB_DMA_IDLE: begin
          xfer_cnt <= '0;
          hdr_idx <= '0;
          if (acq_gate && !gate_d) begin
            xfer_ts <= tstamp;
            dma_st <= dma_meta_en ? ddcb_pkg::DDCB_DMA_HDR : ddcb_pkg::DDCB_DMA_DATA;
          end
        end
        ddcb_pkg::DDCB_DMA_HDR: begin
          if (dma_ready) begin
            hdr_idx <= hdr_idx + 2'd1;
            if (hdr_idx == 2'd2) dma_st <= ddcb_pkg::DDCB_DMA_DATA;
          end
        end
        ddcb_pkg::DDCB_DMA_DATA: begin
          if (pop) xfer_cnt <= xfer_cnt + 16'h1;
          // Gate close ends transfer in gate mode
          if ((dma_gate_mode && !acq_gate && fifo_empty) ||
              (!dma_gate_mode && pop && xfer_cnt + 16'h1 >= dma_len))
            dma_st <= ddcb_pkg::DDCB_DMA_IDLE;
        end
        default: dma_st <= ddcb_pkg::DDCB_DMA_IDLE;
      endcase
    end
  end

  always_comb begin
    dma_word = '0;
    dma_valid = 1'b0;
    if (dma_st == ddcb_pkg::DDCB_DMA_HDR) begin
      dma_valid = 1'b1;
      dma_word.hdr = 1'b1;
      unique case (hdr_idx)
        2'd0: dma_word.data = ddcb_pkg::CH_ID_BASE;
        2'd1: dma_word.data = xfer_ts;
        default: dma_word.data = {16'h0000, dma_len};
      endcase
    end else if (dma_st == ddcb_pkg::DDCB_DMA_DATA && !fifo_empty && !cap_hold) begin
      dma_valid = 1'b1;
      dma_word.data = mem[rptr[AW-1:0]];
      dma_word.last = !dma_gate_mode && (xfer_cnt + 16'h1 >= dma_len);
    end
  end

  // Register read and status clear (write one to clear)
  always_comb begin
    clr_flag = '0;
    sum_clr = wr_en && paddr == ddcb_pkg::REG_SUM_STAT && pwdata[0];
    for (int c = 0; c < NCH; c++)
      clr_flag[c] = wr_en && ch_sel == 4'(c + 1) && ch_off == ddcb_pkg::OFF_STAT && pwdata[0];
  end

  always_comb begin
    prdata = '0;
    pslverr = 1'b0;
    if (rd_en) begin
      if (ch_sel == 4'h0) begin
        unique case (paddr)
          ddcb_pkg::REG_SUM_CFG: prdata = {22'h0, chain_en, sum_thr_above, 5'h0, sum_mask};
          ddcb_pkg::REG_SUM_GAIN: prdata = {16'h0, sum_gain};
          ddcb_pkg::REG_SUM_AVG: prdata = {19'h0, sum_avg_m1};
          ddcb_pkg::REG_SUM_THR: prdata = sum_thr;
          ddcb_pkg::REG_SUM_PWR: prdata = sum_pwr;
          ddcb_pkg::REG_SUM_STAT: prdata = {31'h0, sum_flag};
          ddcb_pkg::REG_DMA_CTRL: prdata = {30'h0, dma_meta_en, dma_gate_mode};
          ddcb_pkg::REG_DMA_LEN: prdata = {16'h0, dma_len};
          ddcb_pkg::REG_TSTAMP: prdata = tstamp;
          default: pslverr = 1'b1;
        endcase
      end else if (ch_sel <= 4'(NCH)) begin
        for (int c = 0; c < NCH; c++) begin
          if (ch_sel == 4'(c + 1)) begin
            unique case (ch_off)
              ddcb_pkg::OFF_CFG: prdata = {25'h0, cfg[c]};
              ddcb_pkg::OFF_TUNE: prdata = tune[c];
              ddcb_pkg::OFF_DECIM: prdata = {16'h0, decim_m1[c]};
              ddcb_pkg::OFF_GAIN: prdata = {16'h0, gain[c]};
              ddcb_pkg::OFF_PHASE: prdata = {16'h0, phase[c]};
              ddcb_pkg::OFF_AVG: prdata = {19'h0, avg_m1[c]};
              ddcb_pkg::OFF_THR: prdata = thr[c];
              ddcb_pkg::OFF_PWR: prdata = pwr[c];
              ddcb_pkg::OFF_STAT: prdata = {31'h0, flag[c]};
              default: prdata = (ch_off >= ddcb_pkg::OFF_COEF && ch_off[7:2] < 6'(16 + TAPS)) ?
                                32'(coef[c][ch_off[4:2]]) : '0;
            endcase
          end
        end
      end else begin
        pslverr = 1'b1;
      end
    end
  end
endmodule // ddcb_acq

// Boxcar power meter with latched threshold crossing flag
module ddcb_pmeter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ddcb_pkg::ddcb_iq_t smp,
  input wire logic smp_v,
  input wire logic [12:0] avg_m1,
  input wire logic [31:0] thr,
  input wire logic above,
  input wire logic clr,
  output logic [31:0] pwr,
  output logic flag
);
  logic [63:0] acc;
  logic [12:0] cnt;
  logic [47:0] inst;
  logic crossed;
  logic crossed_d;
  assign inst = 48'(smp.i * smp.i) + 48'(smp.q * smp.q);
  assign crossed = above ? (pwr > thr) : (pwr < thr);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= '0;
      cnt <= '0;
      pwr <= '0;
    end else if (clk_en && smp_v) begin
      if (cnt >= avg_m1) begin
        cnt <= '0;
        acc <= '0;
        pwr <= 32'((acc + 64'(inst)) / (64'(avg_m1) + 64'h1) >> 16);
      end else begin
        cnt <= cnt + 13'h1;
        acc <= acc + 64'(inst);
      end
    end
  end
  // Latch on crossing edge; set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      crossed_d <= 1'b0;
      flag <= 1'b0;
    end else if (clk_en) begin
      crossed_d <= crossed;
      if (crossed && !crossed_d) flag <= 1'b1;
      else if (clr) flag <= 1'b0;
    end
  end
endmodule // ddcb_pmeter

/* File: ddcb_acq_checker.sv */
// Port-level assertions for the acquisition block
`timescale 1ns/1ps
module ddcb_acq_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire ddcb_pkg::ddcb_iq_t chain_out,
  input wire logic chain_out_valid,
  input wire ddcb_pkg::ddcb_word_t dma_word,
  input wire logic dma_valid,
  input wire logic dma_ready,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_wr_ok; psel && penable && pwrite |-> !pslverr; endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("error on write");
  property p_unmap; psel && penable && !pwrite && paddr == 12'hFFC |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read accepted");
  property p_hold; dma_valid && !dma_ready |=> dma_valid && $stable(dma_word); endproperty
  a_hold: assert property (p_hold) else $error("stalled word dropped");
  property p_rate; chain_out_valid && clk_en |=> !chain_out_valid; endproperty
  a_rate: assert property (p_rate) else $error("beam faster than half rate");
  property p_beam; $changed(chain_out) |-> chain_out_valid; endproperty
  a_beam: assert property (p_beam) else $error("beam changed without valid");
  property p_clear; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  a_clear: assert property (p_clear) else $error("flag dropped by itself");
  property p_freeze; !clk_en |=> $stable(chain_out) && $stable(irq); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  c_beam: cover property (chain_out_valid);
  c_hdr: cover property (dma_valid && dma_ready && dma_word.hdr);
  c_irq: cover property (irq);
endmodule // ddcb_acq_checker
bind ddcb_acq ddcb_acq_checker chk_u (.mclk, .reset_n, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .chain_out, .chain_out_valid, .dma_word, .dma_valid,
  .dma_ready, .irq);

/* File: ddcb_host_model.sv */
// Host-side DMA sink that logs every word it takes
`timescale 1ns/1ps
module ddcb_host_model (
  input wire logic mclk,
  input wire logic stall,
  input wire ddcb_pkg::ddcb_word_t dma_word,
  input wire logic dma_valid,
  output logic dma_ready
);
  ddcb_pkg::ddcb_word_t log_q[$];
  logic tog = 1'b0;
  initial dma_ready = 1'b0;
  // Stalling host accepts every other cycle
  always @(posedge mclk) begin
    if (dma_valid && dma_ready)
      log_q.push_back(dma_word);
    tog <= !tog;
    dma_ready <= !stall || tog;
  end
endmodule // ddcb_host_model

/* File: ddcb_acq_bench.sv */
// Self-checking bench for the acquisition block
`timescale 1ns/1ps
module ddcb_acq_bench;
  logic mclk = 0, reset_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic acq_gate = 0, stall = 1, err, chain_in_valid = 0;
  logic [47:0] chain_in = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] hb, lb;
  logic pready, pslverr, chain_out_valid, dma_valid, dma_ready, irq;
  ddcb_pkg::ddcb_iq_t chain_out;
  ddcb_pkg::ddcb_word_t dma_word;
  int error_cnt = 0, checks_done = 0, n, cnt;
  always #5 mclk = ~mclk;
  ddcb_acq dut_u (.mclk, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adc_data({3{16'h0100}}), .test_data(16'h7FFF),
    .loop_data(16'h0000), .acq_gate, .chain_in, .chain_in_valid, .chain_out,
    .chain_out_valid, .dma_word, .dma_valid, .dma_ready, .irq);
  ddcb_host_model host_u (.mclk, .stall, .dma_word, .dma_valid, .dma_ready);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tmo(input string what);
    chk(what, 32'h0, 32'h1);
    wrap_up;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      tmo("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic t_regs;
    rdchk("decim rst", 12'h108, 32'h1);
    rdchk("gain rst", 12'h20C, 32'h4000);
    rdchk("avg rst", 12'h314, 32'h3FF);
    rdchk("sum gain", 12'h004, 32'h4000);
    apb(1'b1, 12'h108, 32'h0);
    rdchk("decim floor", 12'h108, 32'h1);
    for (int c = 1; c < 4; c++)
      apb(1'b1, 12'(c * 256 + 4), 32'hFFFF_FFF0 + c);
    for (int c = 1; c < 4; c++)
      rdchk("tune", 12'(c * 256 + 4), 32'hFFFF_FFF0 + c);
    apb(1'b1, 12'h140, 32'hFFFC_2345);
    rdchk("coef", 12'h140, 32'h2345);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
  endtask
  task automatic t_beam;
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b1, 12'h208, 32'hFFFF);
    for (int k = 1; k < 4; k += 2) begin
      apb(1'b1, 12'h108, k);
      repeat (40) @(posedge mclk);
      cnt = 0;
      repeat (200) begin
        @(posedge mclk);
        cnt += chain_out_valid;
      end
      chk("beam rate", 200 / (k + 1), cnt);
    end
  endtask
  task automatic t_thr(input logic [31:0] cfg, input logic [31:0] hit, input logic [31:0] miss);
    apb(1'b1, 12'h114, 32'h3);
    apb(1'b1, 12'h100, cfg);
    apb(1'b1, 12'h118, hit);
    for (n = 0; n < 400 && irq !== 1'b1; n++)
      @(posedge mclk);
    if (n == 400)
      tmo("irq");
    rdchk("stat", 12'h120, 32'h1);
    apb(1'b1, 12'h118, miss);
    repeat (40) @(posedge mclk);
    chk("irq held", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h120, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask
  task automatic t_dma(input logic [31:0] ctrl);
    host_u.log_q.delete();
    apb(1'b1, 12'h01C, 32'h5);
    apb(1'b1, 12'h018, ctrl);
    apb(1'b1, 12'h100, {28'h3, ctrl[0], 3'h0});
    acq_gate <= 1'b1;
    repeat (100) @(posedge mclk);
    if (ctrl[0])
      chk("capture hold", 32'h3, host_u.log_q.size());
    acq_gate <= 1'b0;
    repeat (400) @(posedge mclk);
    hb = '0;
    lb = '0;
    foreach (host_u.log_q[i])
      if (i < 8) begin
        hb[i] = host_u.log_q[i].hdr;
        lb[i] = host_u.log_q[i].last;
      end
    chk("hdr words", 32'h7, {29'h0, hb[2:0]});
    chk("gate end", 32'h0, {31'h0, dma_valid});
    if (ctrl[0] == 1'b0) begin
      chk("words", 32'h8, host_u.log_q.size());
      chk("len hdr", 32'h5, host_u.log_q[2].data);
      chk("last", 32'h80, {24'h0, lb});
    end else begin
      chk("gate len", 32'h1, {31'h0, host_u.log_q.size() > 8});
      chk("no last", 32'h0, {24'h0, lb});
    end
  endtask
  task automatic t_chain;
    apb(1'b1, 12'h000, 32'h200);
    chain_in <= 48'h012345_FFF000;
    chain_in_valid <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("chain i", 32'h12345, {8'h0, chain_out.i});
    chk("chain q", 32'hFFF000, {8'h0, chain_out.q});
    chain_in <= 48'h0;
    clk_en <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("frozen", 32'h12345, {8'h0, chain_out.i});
    chain_in <= 48'h012345_FFF000;
    clk_en <= 1'b1;
    apb(1'b1, 12'h004, 32'h8000);
    repeat (20) @(posedge mclk);
    chk("sum gain i", 32'h2468A, {8'h0, chain_out.i});
    chk("sum gain q", 32'hFFE000, {8'h0, chain_out.q});
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_beam;
    t_thr(32'h32, 32'h0, 32'hFFFF_FFFF);
    t_thr(32'h30, 32'hFFFF_FFFF, 32'h0);
    t_chain;
    t_dma(32'h2);
    t_dma(32'h3);
    wrap_up;
  end
endmodule // ddcb_acq_bench
